// [gmt_trigger_top.sv]
// gated measurement trigger: trigger qualification, group capture, AXI4-Lite registers
`timescale 1ns/1ps
module gmt_trigger_top
  import gmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // external trigger pins
  input wire logic trig1_pin,
  input wire logic trig2_pin,
  // acquisition path
  input wire logic chan_valid,
  input wire logic meas_done,
  input wire logic [GMT_NUM_GROUPS-1:0][GMT_DATA_W-1:0] chan_data,
  output logic meas_start,
  // interrupt
  output logic irq,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [GMT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [GMT_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  gmt_trig_if trig ();

  // configuration
  gmt_start_type start_condition_select_q;
  logic input2_qualifier_enable_q;
  logic [GMT_NUM_GROUPS-1:0] group_irq_en_q;
  logic [GMT_STAT_W-1:0] status_q;
  logic [GMT_STAT_W-1:0] mask_q;

  // trigger bookkeeping
  logic [31:0] trig_count_q;
  logic [31:0] miss_count_q;
  logic [31:0] cycle_q;
  logic [31:0] stamp_q;
  logic meas_start_q;
  logic irq_q;

  // bus slave state
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [GMT_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // combinational
  logic selected_edge;
  logic gate_open;
  logic trig_accept;
  logic trig_missed;
  logic do_write;
  logic do_read;
  logic [GMT_NUM_GROUPS-1:0] captured;
  logic [GMT_DATA_W-1:0] sample_rd;
  logic [GMT_IDX_W-1:0] sample_idx;
  logic [GMT_STAT_W-1:0] status_set;
  logic [GMT_STAT_W-1:0] status_clr;
  logic [31:0] wmask;

  // true when the offset falls in the sample window
  function automatic logic is_sample(input logic [GMT_ADDR_W-1:0] a);
    return (a >= GMT_SAMPLE_BASE) && (a <= GMT_SAMPLE_LAST);
  endfunction : is_sample

  // byte strobes expanded to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction : strb_mask

  // true for every offset that answers OKAY
  function automatic logic is_mapped(input logic [GMT_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == GMT_CTRL_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_GROUP_IRQ_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_STATUS_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_MASK_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_PINS_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_TRIG_COUNT_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_MISS_COUNT_ADDR) begin
      hit = 1'b1;
    end else if (a == GMT_STAMP_ADDR) begin
      hit = 1'b1;
    end else if (is_sample(a)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  gmt_edge_detect u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .trig1_pin(trig1_pin),
    .trig2_pin(trig2_pin),
    .trig(trig.det)
  );

  gmt_group_sampler u_sampler (
    .clk(clk),
    .reset_n(reset_n),
    .chan_valid(chan_valid),
    .meas_done(meas_done),
    .chan_data(chan_data),
    .irq_groups(group_irq_en_q),
    .rd_index(sample_idx),
    .rd_data(sample_rd),
    .captured(captured)
  );

  // trigger qualification; one setting pair for every interrupt-mode group
  always_comb begin
    case (start_condition_select_q)
      GMT_START_RISING: selected_edge = trig.rise1;
      GMT_START_FALLING: selected_edge = trig.fall1;
      default: selected_edge = 1'b0;
    endcase
  end

  // input 2 is sampled in the same cycle as the edge of input 1
  assign gate_open = ~input2_qualifier_enable_q | trig.level2;
  assign trig_accept = selected_edge & gate_open;
  assign trig_missed = selected_edge & ~gate_open;

  // start pulse only matters when some group waits on a trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meas_start_q <= 1'b0;
    end else begin
      meas_start_q <= trig_accept & (|group_irq_en_q);
    end
  end

  // counters and a timestamp of the last accepted trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_q <= '0;
      stamp_q <= '0;
      trig_count_q <= '0;
      miss_count_q <= '0;
    end else begin
      cycle_q <= cycle_q + 32'h1;
      if (trig_accept) begin
        stamp_q <= cycle_q;
        trig_count_q <= trig_count_q + 32'h1;
      end
      if (trig_missed) begin
        miss_count_q <= miss_count_q + 32'h1;
      end
    end
  end

  // write channel handshakes; address and data are taken in either order
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  assign wmask = strb_mask(wstrb_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= GMT_RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? GMT_RESP_OKAY : GMT_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration writes; interrupt mode cannot live while starts are off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_condition_select_q <= GMT_START_OFF;
      input2_qualifier_enable_q <= 1'b0;
      group_irq_en_q <= '0;
      mask_q <= '0;
    end else begin
      if (do_write && awaddr_q == GMT_CTRL_ADDR && wstrb_q[0]) begin
        case (wdata_q[GMT_CTRL_MODE_LSB +: GMT_CTRL_MODE_W])
          GMT_START_RISING: start_condition_select_q <= GMT_START_RISING;
          GMT_START_FALLING: start_condition_select_q <= GMT_START_FALLING;
          default: start_condition_select_q <= GMT_START_OFF;
        endcase
        input2_qualifier_enable_q <= wdata_q[GMT_CTRL_QUAL_BIT];
      end
      if (start_condition_select_q == GMT_START_OFF) begin
        group_irq_en_q <= '0;
      end else if (do_write && awaddr_q == GMT_GROUP_IRQ_ADDR) begin
        // each group bit is independent of the others
        group_irq_en_q <= (group_irq_en_q & ~wmask[GMT_NUM_GROUPS-1:0])
          | (wdata_q[GMT_NUM_GROUPS-1:0] & wmask[GMT_NUM_GROUPS-1:0]);
      end
      if (do_write && awaddr_q == GMT_MASK_ADDR) begin
        mask_q <= (mask_q & ~wmask[GMT_STAT_W-1:0])
          | (wdata_q[GMT_STAT_W-1:0] & wmask[GMT_STAT_W-1:0]);
      end
    end
  end

  // sticky status: write one to clear, a new event in the same cycle wins
  assign status_set = {trig_accept, captured};
  assign status_clr = (do_write && awaddr_q == GMT_STATUS_ADDR)
    ? (wdata_q[GMT_STAT_W-1:0] & wmask[GMT_STAT_W-1:0]) : '0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // level interrupt, one cycle behind the status it reflects
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // read channel
  assign do_read = s_axi_arvalid & arready_q;
  assign sample_idx = GMT_IDX_W'((s_axi_araddr - GMT_SAMPLE_BASE) >> 2);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= GMT_RESP_OKAY;
    end else begin
      if (do_read) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= is_mapped(s_axi_araddr) ? GMT_RESP_OKAY : GMT_RESP_SLVERR;
        if (s_axi_araddr == GMT_CTRL_ADDR) begin
          rdata_q <= {29'h0, input2_qualifier_enable_q, start_condition_select_q};
        end else if (s_axi_araddr == GMT_GROUP_IRQ_ADDR) begin
          rdata_q <= {16'h0, group_irq_en_q};
        end else if (s_axi_araddr == GMT_STATUS_ADDR) begin
          rdata_q <= {15'h0, status_q};
        end else if (s_axi_araddr == GMT_MASK_ADDR) begin
          rdata_q <= {15'h0, mask_q};
        end else if (s_axi_araddr == GMT_PINS_ADDR) begin
          rdata_q <= {30'h0, trig.level2, trig.level1};
        end else if (s_axi_araddr == GMT_TRIG_COUNT_ADDR) begin
          rdata_q <= trig_count_q;
        end else if (s_axi_araddr == GMT_MISS_COUNT_ADDR) begin
          rdata_q <= miss_count_q;
        end else if (s_axi_araddr == GMT_STAMP_ADDR) begin
          rdata_q <= stamp_q;
        end else if (is_sample(s_axi_araddr)) begin
          rdata_q <= {16'h0, sample_rd};
        end else begin
          rdata_q <= '0;
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign meas_start = meas_start_q;
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : gmt_trigger_top

// [gmt_pkg.sv]
// shared constants and types for the gated measurement trigger
package gmt_pkg;
  localparam int unsigned GMT_NUM_GROUPS = 16;
  localparam int unsigned GMT_DATA_W = 16;
  localparam int unsigned GMT_ADDR_W = 8;
  localparam int unsigned GMT_IDX_W = 4;

  // register byte offsets
  localparam logic [7:0] GMT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] GMT_GROUP_IRQ_ADDR = 8'h04;
  localparam logic [7:0] GMT_STATUS_ADDR = 8'h08;
  localparam logic [7:0] GMT_MASK_ADDR = 8'h0C;
  localparam logic [7:0] GMT_PINS_ADDR = 8'h10;
  localparam logic [7:0] GMT_TRIG_COUNT_ADDR = 8'h14;
  localparam logic [7:0] GMT_MISS_COUNT_ADDR = 8'h18;
  localparam logic [7:0] GMT_STAMP_ADDR = 8'h1C;
  localparam logic [7:0] GMT_SAMPLE_BASE = 8'h40;
  localparam logic [7:0] GMT_SAMPLE_LAST = 8'h7C;

  // control register fields
  localparam int unsigned GMT_CTRL_MODE_LSB = 0;
  localparam int unsigned GMT_CTRL_MODE_W = 2;
  localparam int unsigned GMT_CTRL_QUAL_BIT = 2;
  // status and mask layout: one bit per group, then the trigger event
  localparam int unsigned GMT_STAT_TRIG_BIT = 16;
  localparam int unsigned GMT_STAT_W = 17;

  localparam logic [1:0] GMT_RESP_OKAY = 2'h0;
  localparam logic [1:0] GMT_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GMT_START_OFF = 2'b00,
    GMT_START_RISING = 2'b01,
    GMT_START_FALLING = 2'b10
  } gmt_start_type;
endpackage : gmt_pkg

// [gmt_trig_if.sv]
// synchronised trigger levels and edges between edge detector and core
`timescale 1ns/1ps
interface gmt_trig_if;
  logic rise1;
  logic fall1;
  logic level1;
  logic level2;
  modport det (output rise1, output fall1, output level1, output level2);
  modport use_side (input rise1, input fall1, input level1, input level2);
endinterface : gmt_trig_if

// [gmt_edge_detect.sv]
// pin synchronisers for both trigger inputs, edge detection for trigger input 1 only
`timescale 1ns/1ps
module gmt_edge_detect
  import gmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // trigger pins
  input wire logic trig1_pin,
  input wire logic trig2_pin,
  // towards the core
  gmt_trig_if.det trig
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      meta_q <= {trig2_pin, trig1_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges compare the synced sample with the one before it
  assign trig.rise1 = sync_q[0] & ~prev_q[0];
  assign trig.fall1 = ~sync_q[0] & prev_q[0];
  assign trig.level1 = sync_q[0];
  assign trig.level2 = sync_q[1];
endmodule : gmt_edge_detect

// [gmt_group_sampler.sv]
// per-group sample storage for the 16 fixed signal groups
`timescale 1ns/1ps
module gmt_group_sampler
  import gmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // acquisition path
  input wire logic chan_valid,
  input wire logic meas_done,
  input wire logic [GMT_NUM_GROUPS-1:0][GMT_DATA_W-1:0] chan_data,
  // configuration
  input wire logic [GMT_NUM_GROUPS-1:0] irq_groups,
  // read side and events
  input wire logic [GMT_IDX_W-1:0] rd_index,
  output logic [GMT_DATA_W-1:0] rd_data,
  output logic [GMT_NUM_GROUPS-1:0] captured
);
  logic [GMT_DATA_W-1:0] store_q [GMT_NUM_GROUPS];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < GMT_NUM_GROUPS; i++) begin
        store_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < GMT_NUM_GROUPS; i++) begin
        if (irq_groups[i]) begin
          if (meas_done) begin
            store_q[i] <= chan_data[i];
          end
        end else if (chan_valid) begin
          store_q[i] <= chan_data[i];
        end
      end
    end
  end

  // groups in interrupt mode report the completed triggered measurement
  assign captured = meas_done ? irq_groups : '0;
  assign rd_data = store_q[rd_index];
endmodule : gmt_group_sampler

// [gmt_trigger_monitor.sv]
// port-level assertion checker for the gated measurement trigger
`timescale 1ns/1ps
module gmt_trigger_monitor
  import gmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // trigger and acquisition
  input wire logic trig1_pin,
  input wire logic meas_start,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_start_single: assert property (meas_start |=> !meas_start)
    else $error("start pulse longer than one cycle");
  // two sync flops plus the registered pulse put the pin change three samples back
  a_start_edge: assert property (
    meas_start |-> $past(trig1_pin, 3) != $past(trig1_pin, 4))
    else $error("start without a trigger 1 edge");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
endmodule : gmt_trigger_monitor

bind gmt_trigger_top gmt_trigger_monitor mon_u (
  .clk(clk), .reset_n(reset_n), .trig1_pin(trig1_pin), .meas_start(meas_start),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// [gmt_acq_model.sv]
// acquisition path model answering measurement start pulses
`timescale 1ns/1ps
module gmt_acq_model
  import gmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench control
  input wire logic slow,
  input wire logic free_req,
  input wire logic [15:0] base,
  // towards the block
  input wire logic meas_start,
  output logic meas_done,
  output logic chan_valid,
  output logic [GMT_NUM_GROUPS-1:0][GMT_DATA_W-1:0] chan_data
);
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 4'h0;
    end else if (meas_start) begin
      wait_q <= slow ? 4'h6 : 4'h1;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
  assign meas_done = (wait_q == 4'h1);
  // no free-running acquisition unless the bench asks for a poll
  assign chan_valid = free_req;
  // data is inverted outside its valid cycle so a late load is caught
  always_comb begin
    // all sixteen channels fitted, each one driven from base and its index
    for (int i = 0; i < GMT_NUM_GROUPS; i++) begin
      chan_data[i] = (meas_done || chan_valid) ? base ^ 16'(i) : ~(base ^ 16'(i));
    end
  end
endmodule : gmt_acq_model

// [tb.sv]
// self-checking bench for the gated measurement trigger
`timescale 1ns/1ps
module tb
  import gmt_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, trig1_pin = 1'b0, trig2_pin = 1'b0;
  logic slow = 1'b0, free_req = 1'b0, meas_done, chan_valid, meas_start, irq;
  logic [15:0] base = 16'hA5C3;
  logic [GMT_NUM_GROUPS-1:0][GMT_DATA_W-1:0] chan_data;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [GMT_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  int compares = 0, miscompares = 0, starts = 0;

  gmt_trigger_top dut_u (.clk(clk), .reset_n(reset_n), .trig1_pin(trig1_pin),
    .trig2_pin(trig2_pin), .chan_valid(chan_valid), .meas_done(meas_done),
    .chan_data(chan_data), .meas_start(meas_start), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  gmt_acq_model acq_u (.clk(clk), .reset_n(reset_n), .slow(slow), .free_req(free_req),
    .base(base), .meas_start(meas_start), .meas_done(meas_done),
    .chan_valid(chan_valid), .chan_data(chan_data));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (meas_start === 1'b1) starts++;
  end

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok = 0;
    bit w_ok = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rdv);
    chk(rdv, exp);
  endtask : rc

  // gate level settles first so it is stable when the trigger 1 edge is seen
  task automatic pins(input logic t1, input logic t2, input int exp);
    int s0;
    @(posedge clk);
    s0 = starts;
    trig2_pin <= t2;
    repeat (4) @(posedge clk);
    trig1_pin <= t1;
    repeat (12) @(posedge clk);
    chk(32'(starts - s0), 32'(exp));
  endtask : pins

  task automatic t_reset();
    rc(GMT_CTRL_ADDR, 32'h0);
    rc(GMT_STATUS_ADDR, 32'h0);
    rc(8'h20, 32'h0);
    chk({30'h0, last_resp}, {30'h0, GMT_RESP_SLVERR});
    wr(8'h24, 32'h1);
    chk({30'h0, last_resp}, {30'h0, GMT_RESP_SLVERR});
  endtask : t_reset

  task automatic t_off();
    wr(GMT_GROUP_IRQ_ADDR, 32'h0000FFFF);
    rc(GMT_GROUP_IRQ_ADDR, 32'h0);
    pins(1'b1, 1'b1, 0);
    pins(1'b0, 1'b1, 0);
    rc(GMT_TRIG_COUNT_ADDR, 32'h0);
  endtask : t_off

  task automatic t_rising();
    wr(GMT_CTRL_ADDR, 32'h1);
    wr(GMT_GROUP_IRQ_ADDR, 32'h5);
    rc(GMT_GROUP_IRQ_ADDR, 32'h5);
    pins(1'b1, 1'b0, 1);
    pins(1'b0, 1'b0, 0);
    rc(GMT_STATUS_ADDR, 32'h00010005);
    chk({31'h0, irq}, 32'h0);
    wr(GMT_MASK_ADDR, 32'h00010005);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rc(GMT_SAMPLE_BASE, {16'h0, base});
    rc(GMT_SAMPLE_BASE + 8'h08, {16'h0, base ^ 16'h2});
    rc(GMT_SAMPLE_BASE + 8'h04, 32'h0);
    wr(GMT_STATUS_ADDR, 32'h0001FFFF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_rising

  task automatic t_falling_gate();
    wr(GMT_CTRL_ADDR, 32'h6);
    slow <= 1'b1;
    pins(1'b1, 1'b1, 0);
    pins(1'b0, 1'b0, 0);
    rc(GMT_MISS_COUNT_ADDR, 32'h1);
    pins(1'b1, 1'b1, 0);
    pins(1'b0, 1'b1, 1);
    rc(GMT_TRIG_COUNT_ADDR, 32'h2);
    rc(GMT_STATUS_ADDR, 32'h00010005);
  endtask : t_falling_gate

  task automatic t_free();
    @(posedge clk);
    base <= 16'h3C3C;
    // one poll per data change keeps the host ahead of the signal
    free_req <= 1'b1;
    @(posedge clk);
    free_req <= 1'b0;
    rc(GMT_SAMPLE_BASE + 8'h04, 32'h00003C3D);
    rc(GMT_SAMPLE_BASE, 32'h0000A5C3);
    wr(GMT_CTRL_ADDR, 32'h0);
    rc(GMT_GROUP_IRQ_ADDR, 32'h0);
    pins(1'b1, 1'b1, 0);
    rc(GMT_PINS_ADDR, 32'h3);
    wr(GMT_CTRL_ADDR, 32'h3);
    rc(GMT_CTRL_ADDR, 32'h0);
    pins(1'b0, 1'b1, 0);
  endtask : t_free

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_off();
    t_rising();
    t_falling_gate();
    t_free();
    wrap_up();
  end

  // the sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb
